// ---- src/daa_ctrl_map.svh ----
`ifndef DAA_CTRL_MAP_SVH
`define DAA_CTRL_MAP_SVH

// Register indices; byte address is four times the index
`define LRH_IDX        3'h5
`define PDC_IDX        3'h6
`define SRC_IDX        3'h7
`define IRQ_STAT_ADDR  4'h0
`define IRQ_MASK_ADDR  4'h1
`define SAMP_CFG_ADDR  4'h2

// Line ring hook control fields
`define NEG_RING_BIT   6
`define POS_RING_BIT   5
`define MONITOR_BIT    3
`define RING_DET_BIT   2
`define OFFHOOK_BIT    0
`define LRH_RESET      8'h00
`define LRH_WMASK      8'h09

// Power down control fields
`define LINE_PD_BIT    4
`define SYS_PD_BIT     3
`define PDC_RESET      8'h10
`define PDC_WMASK      8'h18

// Sample rate control fields
`define HIGH_SPEED_BIT 3
`define SRC_RESET      8'h00
`define SRC_WMASK      8'h08

// Own config register: full wave ring option in bit 0
`define FWR_BIT        0

// Interrupt status bits
`define IRQ_RING_BIT   0
`define IRQ_POS_BIT    1
`define IRQ_NEG_BIT    2
`define IRQ_WIDTH      3

// Timing: clock 50 MHz
`define CLK_HZ         50000000
`define RING_HOLD_S    5
`define FRAME_HZ       8000
`define FRAME_CYCLES   (`CLK_HZ / `FRAME_HZ)
`define RING_HOLD_CYC  (`CLK_HZ * `RING_HOLD_S)

`endif

// ---- src/daa_ctrl_pkg.sv ----
package daa_ctrl_pkg;
  typedef enum logic [1:0] {BUS_IDLE, BUS_ACK} bus_state_e;
  typedef logic [7:0] reg_t;
endpackage

// ---- src/daa_line_control_regs.sv ----
// Operation
// [RQ1] Negative ring status follows negative ring input
// [RQ2] Positive ring status follows positive ring input
// [RQ3] On-hook monitor bit enables low-power monitoring
// [RQ4] Ring detect clears 5 s after ring, or off-hook; the hold timer starts on positive ring only
// [RQ5] Full-wave option lets either polarity set detect
// [RQ6] Off-hook bit drives line side off-hook
// [RQ7] Line power-down bit resets to one
// [RQ8] Host configures clock before clearing line power-down
// [RQ9] System power-down bit powers system side down
// [RQ10] System side stays down until reset
// [RQ11] Sample rate 8 kHz, or 16 kHz high-speed
// [RQ12] High-speed puts two samples per 8 kHz frame
// [RQ13] Read-only and reserved bits ignore writes, read zero
`include "daa_ctrl_map.svh"
module daa_line_control_regs #(
  parameter int unsigned RING_HOLD_CYCLES = `RING_HOLD_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Avalon-MM slave
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // Line side detector inputs
  input  wire logic        posRing,
  input  wire logic        negRing,
  // Line side controls
  output logic             offhookOut,
  output logic             onhookMonitorOut,
  output logic             lineSidePowerDownOut,
  output logic             systemSidePowerDownOut,
  // Sampling
  output logic             sampleStrobe,
  output logic             frameStrobe,
  output logic             slotSelect,
  // Interrupt
  output logic             irq
);
  daa_ctrl_pkg::bus_state_e busState_q;
  daa_ctrl_pkg::bus_state_e busState_d;
  daa_ctrl_pkg::reg_t       lrh_q;
  daa_ctrl_pkg::reg_t       lrh_d;
  daa_ctrl_pkg::reg_t       pdc_q;
  daa_ctrl_pkg::reg_t       pdc_d;
  daa_ctrl_pkg::reg_t       src_q;
  daa_ctrl_pkg::reg_t       src_d;
  logic [`IRQ_WIDTH-1:0]    irqStat_q;
  logic [`IRQ_WIDTH-1:0]    irqStat_d;
  logic [`IRQ_WIDTH-1:0]    irqMask_q;
  logic [`IRQ_WIDTH-1:0]    irqMask_d;
  logic                     fullWave_q;
  logic                     fullWave_d;
  logic [31:0]              readdata_d;
  logic                     posRing_q;
  logic                     negRing_q;
  logic                     ringSet;
  logic                     holdRunning;
  logic                     holdDone;
  logic                     wrHit;
  logic                     rdHit;
  logic [15:0]              divCnt_q;
  logic [15:0]              divCnt_d;
  logic                     sampStb_d;
  logic                     frameStb_d;
  logic                     slot_d;
  logic                     sampStb_q;
  logic                     frameStb_q;
  logic                     slot_q;
  logic                     irq_q;
  logic                     waitrequest_d;
  logic                     irq_d;
  logic                     offhook_d;
  logic                     monitor_d;
  logic                     linePd_d;
  logic                     sysPd_d;

  // Word index from byte address; all 6 bits decoded, low 2 must be zero
  function automatic logic isReg(input logic [5:0] addr, input logic [3:0] idx);
    return (addr[5:2] == idx) && (addr[1:0] == 2'b00);
  endfunction

  // Merge only the writable bits of a register
  function automatic daa_ctrl_pkg::reg_t maskWrite(
    input daa_ctrl_pkg::reg_t oldVal,
    input daa_ctrl_pkg::reg_t newVal,
    input daa_ctrl_pkg::reg_t wmask
  );
    return (oldVal & ~wmask) | (newVal & wmask);
  endfunction

  // Requests count only while the handshake is idle
  assign wrHit   = write && (busState_q == daa_ctrl_pkg::BUS_IDLE);
  assign rdHit   = read && (busState_q == daa_ctrl_pkg::BUS_IDLE);
  assign ringSet = posRing_q || (fullWave_q && negRing_q); // [RQ5]

  // Hold timer restarts on every cycle of positive ring
  ring_hold_timer #(
    .HOLD_CYCLES (RING_HOLD_CYCLES)
  ) u_hold (
    .clk     (clk),
    .reset   (reset),
    .start   (posRing_q),
    .abort   (lrh_q[`OFFHOOK_BIT]),
    .running (holdRunning),
    .done    (holdDone)
  );

  // Bus handshake: one wait cycle, answer on the second
  always_comb
  begin
    busState_d    = busState_q;
    waitrequest_d = 1'b1;
    unique case (busState_q)
      daa_ctrl_pkg::BUS_IDLE:
        if (read || write)
        begin
          busState_d    = daa_ctrl_pkg::BUS_ACK;
          waitrequest_d = 1'b0;
        end
      daa_ctrl_pkg::BUS_ACK:
        busState_d = daa_ctrl_pkg::BUS_IDLE;
      default:
        busState_d = daa_ctrl_pkg::BUS_IDLE;
    endcase
  end

  // Register file
  always_comb
  begin
    lrh_d      = lrh_q;
    pdc_d      = pdc_q;
    src_d      = src_q;
    irqMask_d  = irqMask_q;
    fullWave_d = fullWave_q;
    irqStat_d  = irqStat_q;
    readdata_d = readdata;
    if (wrHit)
    begin
      if (isReg(address, {1'b0, `LRH_IDX}))
        lrh_d = maskWrite(lrh_q, writedata[7:0], `LRH_WMASK); // [RQ13]
      if (isReg(address, {1'b0, `PDC_IDX}) && !pdc_q[`SYS_PD_BIT])
        pdc_d = maskWrite(pdc_q, writedata[7:0], `PDC_WMASK); // [RQ9] [RQ10]
      if (isReg(address, {1'b0, `SRC_IDX}))
        src_d = maskWrite(src_q, writedata[7:0], `SRC_WMASK); // [RQ11]
      if (isReg(address, `IRQ_MASK_ADDR))
        irqMask_d = writedata[`IRQ_WIDTH-1:0];
      if (isReg(address, `SAMP_CFG_ADDR))
        fullWave_d = writedata[`FWR_BIT];
    end
    // Live ring status bits
    lrh_d[`NEG_RING_BIT] = negRing_q; // [RQ1]
    lrh_d[`POS_RING_BIT] = posRing_q; // [RQ2]
    // Ring detect: set by ring, cleared by timeout or off-hook
    if (lrh_q[`OFFHOOK_BIT] || holdDone)
      lrh_d[`RING_DET_BIT] = 1'b0; // [RQ4]
    if (ringSet && !lrh_q[`OFFHOOK_BIT])
      lrh_d[`RING_DET_BIT] = 1'b1; // [RQ5]
    // Read path: unmapped and reserved bits return zero
    if (rdHit)
    begin
      readdata_d = 32'h0; // [RQ13]
      if (isReg(address, {1'b0, `LRH_IDX}))
        readdata_d[7:0] = lrh_q;
      else if (isReg(address, {1'b0, `PDC_IDX}))
        readdata_d[7:0] = pdc_q;
      else if (isReg(address, {1'b0, `SRC_IDX}))
        readdata_d[7:0] = src_q;
      else if (isReg(address, `IRQ_STAT_ADDR))
        readdata_d[`IRQ_WIDTH-1:0] = irqStat_q;
      else if (isReg(address, `IRQ_MASK_ADDR))
        readdata_d[`IRQ_WIDTH-1:0] = irqMask_q;
      else if (isReg(address, `SAMP_CFG_ADDR))
        readdata_d[`FWR_BIT] = fullWave_q;
      if (isReg(address, `IRQ_STAT_ADDR))
        irqStat_d = '0;
    end
    // Set wins over read clear
    if (ringSet && !lrh_q[`RING_DET_BIT])
      irqStat_d[`IRQ_RING_BIT] = 1'b1;
    if (posRing_q && !lrh_q[`POS_RING_BIT])
      irqStat_d[`IRQ_POS_BIT] = 1'b1;
    if (negRing_q && !lrh_q[`NEG_RING_BIT])
      irqStat_d[`IRQ_NEG_BIT] = 1'b1;
    // Outputs follow the register bits they copy
    irq_d     = |(irqStat_d & irqMask_d);
    offhook_d = lrh_d[`OFFHOOK_BIT]; // [RQ6]
    monitor_d = lrh_d[`MONITOR_BIT]; // [RQ3]
    linePd_d  = pdc_d[`LINE_PD_BIT]; // [RQ7]
    sysPd_d   = pdc_d[`SYS_PD_BIT]; // [RQ9]
  end

  // Sampling divider: 8 kHz frame, two samples per frame in high speed
  always_comb
  begin
    divCnt_d   = divCnt_q + 16'h1;
    frameStb_d = 1'b0;
    sampStb_d  = 1'b0;
    slot_d     = slot_q;
    if (divCnt_q == 16'(`FRAME_CYCLES - 1))
    begin
      divCnt_d   = 16'h0;
      frameStb_d = 1'b1;
      sampStb_d  = 1'b1; // [RQ11]
      slot_d     = 1'b0;
    end
    // Second strobe half way through the frame
    else if (src_q[`HIGH_SPEED_BIT] && divCnt_q == 16'(`FRAME_CYCLES / 2 - 1))
    begin
      sampStb_d = 1'b1; // [RQ12]
      slot_d    = 1'b1; // [RQ12]
    end
    // System power-down freezes the divider
    if (pdc_q[`SYS_PD_BIT])
    begin
      divCnt_d   = divCnt_q;
      frameStb_d = 1'b0;
      sampStb_d  = 1'b0;
    end
  end

  // Bus handshake state
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      busState_q  <= daa_ctrl_pkg::BUS_IDLE;
      waitrequest <= 1'b1;
    end
    else
    begin
      busState_q  <= busState_d;
      waitrequest <= waitrequest_d;
    end
  end

  // Registers, synchronised ring inputs and registered outputs
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      lrh_q                  <= `LRH_RESET;
      pdc_q                  <= `PDC_RESET; // [RQ7]
      src_q                  <= `SRC_RESET;
      irqStat_q              <= '0;
      irqMask_q              <= '0;
      fullWave_q             <= 1'b0;
      readdata               <= 32'h0;
      posRing_q              <= 1'b0;
      negRing_q              <= 1'b0;
      irq_q                  <= 1'b0;
      offhookOut             <= 1'b0;
      onhookMonitorOut       <= 1'b0;
      lineSidePowerDownOut   <= 1'b1; // [RQ7]
      systemSidePowerDownOut <= 1'b0; // [RQ10]
    end
    else
    begin
      lrh_q                  <= lrh_d;
      pdc_q                  <= pdc_d;
      src_q                  <= src_d;
      irqStat_q              <= irqStat_d;
      irqMask_q              <= irqMask_d;
      fullWave_q             <= fullWave_d;
      readdata               <= readdata_d;
      posRing_q              <= posRing;
      negRing_q              <= negRing;
      irq_q                  <= irq_d;
      offhookOut             <= offhook_d;
      onhookMonitorOut       <= monitor_d;
      lineSidePowerDownOut   <= linePd_d;
      systemSidePowerDownOut <= sysPd_d;
    end
  end

  // Sample and frame divider
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      divCnt_q   <= 16'h0;
      sampStb_q  <= 1'b0;
      frameStb_q <= 1'b0;
      slot_q     <= 1'b0;
    end
    else
    begin
      divCnt_q   <= divCnt_d;
      sampStb_q  <= sampStb_d;
      frameStb_q <= frameStb_d;
      slot_q     <= slot_d;
    end
  end

  assign sampleStrobe = sampStb_q;
  assign frameStrobe  = frameStb_q;
  assign slotSelect   = slot_q;
  assign irq          = irq_q;
endmodule

// ---- src/ring_hold_timer.sv ----
`include "daa_ctrl_map.svh"
// Retriggerable hold timer: done pulses when count expires
module ring_hold_timer #(
  parameter int unsigned HOLD_CYCLES = `RING_HOLD_CYC
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Control
  input  wire logic start,
  input  wire logic abort,
  // Status
  output logic      running,
  output logic      done
);
  logic [27:0] count_q;
  logic [27:0] count_d;
  logic        run_q;
  logic        run_d;
  logic        done_q;
  logic        done_d;

  always_comb
  begin
    count_d = count_q;
    run_d   = run_q;
    done_d  = 1'b0;
    if (abort)
    begin
      run_d   = 1'b0;
      count_d = 28'h0;
    end
    else if (start)
    begin
      run_d   = 1'b1;
      count_d = 28'(HOLD_CYCLES - 1);
    end
    else if (run_q)
    begin
      if (count_q == 28'h0)
      begin
        run_d  = 1'b0;
        done_d = 1'b1;
      end
      else
      begin
        count_d = count_q - 28'h1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      count_q <= 28'h0;
      run_q   <= 1'b0;
      done_q  <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      run_q   <= run_d;
      done_q  <= done_d;
    end
  end

  assign running = run_q;
  assign done    = done_q;
endmodule

// ---- verification/daa_line_control_regs_checker.sv ----
module daa_line_control_regs_checker #(
  parameter int unsigned RING_HOLD_CYCLES = 50
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // Bus
  input wire logic [5:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // Line controls
  input wire logic        offhookOut,
  input wire logic        onhookMonitorOut,
  input wire logic        lineSidePowerDownOut,
  input wire logic        systemSidePowerDownOut,
  input wire logic        frameStrobe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  logic [12:0] frmCnt_q;
  logic [12:0] frmCnt_d;
  logic        seen_q;
  logic        seen_d;
  // Cycles since the last frame strobe
  always_comb
  begin
    frmCnt_d = frameStrobe ? 13'h0 : frmCnt_q + 13'h1;
    seen_d   = seen_q | frameStrobe;
  end
  always_ff @(posedge clk)
  begin
    frmCnt_q <= reset ? 13'h0 : frmCnt_d;
    seen_q   <= reset ? 1'b0 : seen_d;
  end
  sequence rdOk(logic [5:0] a);
    read && !waitrequest && address == a;
  endsequence
  chk_wait_single: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low longer than one cycle");
  chk_answer_req: assert property (!waitrequest |-> read || write)
    else $error("answer without a request");
  chk_reset_vals: assert property ($fell(reset) |-> waitrequest && lineSidePowerDownOut
    && !offhookOut && !systemSidePowerDownOut) else $error("bad values after reset");
  chk_sys_pd_sticky: assert property (systemSidePowerDownOut |=> systemSidePowerDownOut)
    else $error("system power down left without reset");
  chk_hook_read: assert property (rdOk(6'h14) |-> readdata[0] == offhookOut
    && readdata[3] == onhookMonitorOut && readdata[1] == 1'b0 && readdata[4] == 1'b0
    && readdata[31:7] == 25'h0) else $error("hook register and outputs disagree");
  chk_pdc_read: assert property (rdOk(6'h18) |-> readdata ==
    {27'h0, lineSidePowerDownOut, systemSidePowerDownOut, 3'h0})
    else $error("power register and outputs disagree");
  chk_rate_rsvd: assert property (rdOk(6'h1c) |-> (readdata & 32'hfffffff7) == 32'h0)
    else $error("reserved rate bits not zero");
  chk_unmapped_zero: assert property (rdOk(6'h3c) |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_frame_period: assert property (frameStrobe && seen_q && !systemSidePowerDownOut
    |-> frmCnt_q == 13'h1869) else $error("frame period wrong");
endmodule

bind daa_line_control_regs daa_line_control_regs_checker #(
  .RING_HOLD_CYCLES(RING_HOLD_CYCLES)
) u_chk (
  .clk(clk), .reset(reset), .address(address), .read(read), .write(write),
  .readdata(readdata), .waitrequest(waitrequest), .offhookOut(offhookOut),
  .onhookMonitorOut(onhookMonitorOut), .lineSidePowerDownOut(lineSidePowerDownOut),
  .systemSidePowerDownOut(systemSidePowerDownOut), .frameStrobe(frameStrobe)
);

// ---- verification/testbench.sv ----
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, reset, read, write, posRing, negRing, waitrequest, irq;
  logic        offhookOut, onhookMonitorOut, lineSidePowerDownOut, systemSidePowerDownOut;
  logic        sampleStrobe, frameStrobe, slotSelect;
  logic [5:0]  address;
  logic [31:0] writedata, readdata;
  logic [7:0]  q, d;
  int          mismatches, n_tests, seed, cnt, sl;
  daa_line_control_regs #(.RING_HOLD_CYCLES(50)) u_daa_line_control_regs (
    .clk(clk), .reset(reset), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .posRing(posRing), .negRing(negRing), .offhookOut(offhookOut),
    .onhookMonitorOut(onhookMonitorOut), .lineSidePowerDownOut(lineSidePowerDownOut),
    .systemSidePowerDownOut(systemSidePowerDownOut), .sampleStrobe(sampleStrobe),
    .frameStrobe(frameStrobe), .slotSelect(slotSelect), .irq(irq));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic bus(input bit wr, input logic [5:0] a, input logic [7:0] dv);
    @(posedge clk);
    address <= a;
    writedata <= {24'h0, dv};
    read <= !wr;
    write <= wr;
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    `CHK(q, e)
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic ring(input logic p, input logic n);
    @(posedge clk);
    posRing <= p;
    negRing <= n;
    wait_n(4);
  endtask
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (50000) @(posedge clk);
    mismatches++;
    give_verdict;
  end
  initial
  begin
    {reset, read, write, posRing, negRing} = 5'h10;
    address = 6'h00;
    writedata = 32'h0;
    seed = 4728;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    rd(6'h14, 8'h00);
    rd(6'h18, 8'h10);
    rd(6'h1c, 8'h00);
    `CHK(lineSidePowerDownOut, 1'b1)
    bus(1'b1, 6'h14, 8'hff);
    rd(6'h14, 8'h09);
    `CHK({offhookOut, onhookMonitorOut}, 2'b11)
    bus(1'b1, 6'h14, 8'h00);
    wait_n(2);
    `CHK({offhookOut, onhookMonitorOut}, 2'b00)
    // Interrupts unmasked, positive then both polarities
    bus(1'b1, 6'h04, 8'h07);
    ring(1'b1, 1'b0);
    rd(6'h14, 8'h24);
    `CHK(irq, 1'b1)
    ring(1'b1, 1'b1);
    rd(6'h14, 8'h64);
    ring(1'b0, 1'b0);
    rd(6'h00, 8'h07);
    wait_n(2);
    `CHK(irq, 1'b0)
    rd(6'h14, 8'h04);
    wait_n(70);
    rd(6'h14, 8'h00);
    // Masked, full-wave, negative ring only, then off-hook
    bus(1'b1, 6'h04, 8'h00);
    bus(1'b1, 6'h08, 8'h01);
    ring(1'b0, 1'b1);
    rd(6'h14, 8'h44);
    `CHK(irq, 1'b0)
    ring(1'b0, 1'b0);
    bus(1'b1, 6'h14, 8'h01);
    rd(6'h14, 8'h01);
    bus(1'b1, 6'h14, 8'h00);
    bus(1'b1, 6'h08, 8'h00);
    rd(6'h00, 8'h05);
    bus(1'b1, 6'h3c, 8'hff);
    rd(6'h3c, 8'h00);
    bus(1'b1, 6'h18, 8'he7);
    rd(6'h18, 8'h00);
    `CHK(lineSidePowerDownOut, 1'b0)
    // Samples per frame in both rate modes
    for (int i = 0; i < 2; i++)
    begin
      d = 8'($random(seed));
      d[3] = i[0];
      bus(1'b1, 6'h1c, d);
      rd(6'h1c, d & 8'h08);
      do @(negedge clk); while (frameStrobe !== 1'b1);
      cnt = 0;
      sl = 0;
      repeat (6250)
      begin
        if (sampleStrobe === 1'b1)
        begin
          cnt++;
          if (slotSelect === 1'b1)
            sl++;
        end
        @(negedge clk);
      end
      `CHK(cnt, d[3] ? 2 : 1)
      `CHK(sl, d[3] ? 1 : 0)
    end
    bus(1'b1, 6'h18, 8'h08);
    wait_n(2);
    `CHK(systemSidePowerDownOut, 1'b1)
    bus(1'b1, 6'h18, 8'h10);
    rd(6'h18, 8'h08);
    @(posedge clk);
    reset <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    rd(6'h18, 8'h10);
    `CHK(systemSidePowerDownOut, 1'b0)
    give_verdict;
  end
endmodule
